// ==== design/pmcs_port.sv ====
// Wide bus master port: command splitter with a command match monitor.
//
// Design decision made here: the strobed register port.
`default_nettype none
`include "pmcs_map.svh"
// How it works
// - Capture matches only while enable bit set
// - Control holds size, direction, master compares
// - Source bit picks DMA or slave port
// - Compare logic master number and slave width
// - Each criterion gated by its own enable
// - Address register supplies low address word
// - Master is 128 bits wide, any slaves
// - Singles carry 1 to 16 unaligned bytes
// - Unaligned burst ends go out as singles
// - Bursts are 2 to 16 quadwords
// - Bursts split at the configured limit
// - Lines issued aligned, eight words long
// - Four-word lines become single transfers
// - Line reads rounded down to quadword
// - Line writes start at line's first word
// - Match outcome kept in status registers
module pmcs_port
  import pmcs_pkg::*;
(
  input wire logic i_core_clk, // Core clock, 100 MHz
  input wire logic i_rst_b, // Asynchronous reset, active low
  input wire logic [7:0] i_reg_addr, // Register offset
  input wire logic [31:0] i_reg_wdata, // Register write data
  input wire logic i_reg_wr, // Register write strobe
  input wire logic i_reg_rd, // Register read strobe
  output logic [31:0] o_reg_rdata, // Read data, cycle after strobe
  input wire logic i_req_valid, // Upstream request present
  output logic o_req_ready, // Port idle, request taken
  input wire logic [1:0] i_req_kind, // Single, burst, line4, line8
  input wire logic [35:0] i_req_addr, // Start byte address
  input wire logic [12:0] i_req_len, // Byte count, single/burst
  input wire logic i_req_rnw, // 1: read, 0: write
  input wire logic [2:0] i_req_mid, // Originating master number
  input wire logic i_req_from_slave_port, // 1: slave port, 0: DMA
  input wire logic [1:0] i_req_lmid, // External logic master
  output logic o_cmd_valid, // Bus request
  output logic [35:0] o_cmd_addr, // Bus address
  output logic [3:0] o_cmd_size, // Bus size code
  output logic o_cmd_rnw, // Bus direction
  output logic [15:0] o_cmd_be, // Byte enables of 128-bit lane
  output logic [4:0] o_cmd_qwords, // Burst length in quadwords
  input wire logic i_plb_addr_ack, // Slave took the address
  input wire logic [1:0] i_plb_ssize, // Slave width, with the ack
  output logic o_match_hit // Sticky match flag
);
  pmcs_regs_t q; // Registered state
  pmcs_regs_t n; // Next state
  logic [3:0] off; // Byte offset in the quadword
  logic [4:0] room; // Bytes left to quadword end
  logic [12:0] chunk; // Bytes of the next single
  logic [4:0] lim_qw; // Burst limit in quadwords
  logic [8:0] avail_qw; // Whole quadwords remaining
  logic [4:0] burst_qw; // Quadwords of the next burst
  logic [31:0] be_wide; // Byte mask before trimming
  logic issue; // Command taken this cycle
  logic hit_raw; // Matcher result
  logic capture; // Match to be recorded

  //////////////////////////////////////////////////////////////////////
  // Match monitor on the command being taken
  pmcs_matcher u_match (
    .i_ctl(q.ctl),
    .i_adr(q.adr),
    .i_size(q.cmd_size),
    .i_rnw(q.rnw),
    .i_mid(q.mid),
    .i_src(q.src),
    .i_lmid(q.lmid),
    .i_ssize(i_plb_ssize),
    .i_addr(q.cmd_addr[31:0]),
    .o_hit(hit_raw)
  );

  //////////////////////////////////////////////////////////////////////
  // Planning arithmetic for the next command
  always_comb begin
    off = q.addr[3:0];
    room = 5'h10 - {1'b0, off};
    // Head bytes up to the quadword edge, never past it
    chunk = (q.rem < {8'h0, room}) ? q.rem : {8'h0, room};
    lim_qw = `PMCS_MIN_QW << q.lim;
    avail_qw = q.rem[12:4];
    burst_qw = (avail_qw < {4'h0, lim_qw}) ?
      avail_qw[4:0] : lim_qw;
    // Mask of chunk bytes starting at the offset
    be_wide = ((32'h1 << chunk[4:0]) - 32'h1) << off;
    issue = q.cmd_valid && i_plb_addr_ack;
    // Matches are taken at the moment of issue only
    capture = issue && hit_raw && q.ctl[`PMCS_CTL_EN];
  end

  //////////////////////////////////////////////////////////////////////
  // Next state: registers, sequencer, match records
  always_comb begin
    n = q;
    n.rdata = 32'h0;
    // Register writes
    if (i_reg_wr) begin
      case (i_reg_addr)
        `PMCS_OFS_CTL: n.ctl = i_reg_wdata;
        `PMCS_OFS_ADR: n.adr = i_reg_wdata;
        `PMCS_OFS_LIM: n.lim = i_reg_wdata[1:0];
        `PMCS_OFS_STAT: begin
          // Write one to clear the sticky flag
          if (i_reg_wdata[`PMCS_STAT_HIT]) begin
            n.hit = 1'b0;
          end
        end
        `PMCS_OFS_HCNT: n.hit_cnt = 32'h0; // Any write clears
        default: ;
      endcase
    end
    // Register reads, unmapped offsets answer zero
    if (i_reg_rd) begin
      case (i_reg_addr)
        `PMCS_OFS_CTL: n.rdata = q.ctl;
        `PMCS_OFS_ADR: n.rdata = q.adr;
        `PMCS_OFS_LIM: n.rdata = {30'h0, q.lim};
        `PMCS_OFS_STAT: n.rdata = {31'h0, q.hit};
        `PMCS_OFS_HADR: n.rdata = q.hit_addr;
        `PMCS_OFS_HCNT: n.rdata = q.hit_cnt;
        default: n.rdata = 32'h0;
      endcase
    end
    // Record a match; the set wins over a clear in the same cycle
    if (capture) begin
      n.hit = 1'b1;
      n.hit_addr = q.cmd_addr[31:0];
      n.hit_cnt = q.hit_cnt + 32'h1;
    end
    // Command sequencer
    case (q.state)
      PMCS_ST_IDLE: begin
        if (i_req_valid) begin
          n.kind = pmcs_kind_t'(i_req_kind);
          n.rnw = i_req_rnw;
          n.mid = i_req_mid;
          n.src = i_req_from_slave_port;
          n.lmid = i_req_lmid;
          n.addr = i_req_addr;
          n.rem = i_req_len;
          n.state = PMCS_ST_PLAN;
          if (pmcs_kind_t'(i_req_kind) == PMCS_K_LINE4) begin
            // Short lines go out as one aligned quadword single
            n.addr = i_req_addr & `PMCS_QW_MASK;
            n.rem = `PMCS_QW_BYTES;
          end else if (pmcs_kind_t'(i_req_kind) == PMCS_K_LINE8) begin
            n.rem = `PMCS_LINE_BYTES;
          end
        end
      end
      PMCS_ST_PLAN: begin
        n.cmd_be = 16'hFFFF;
        n.cmd_qw = 5'h0;
        n.cmd_addr = q.addr;
        if (q.rem == 13'h0) begin
          // Empty request: nothing to issue
          n.state = PMCS_ST_IDLE;
        end else if (q.kind == PMCS_K_LINE8) begin
          n.cmd_size = `PMCS_SZ_LINE8;
          n.step = q.rem;
          if (q.rnw) begin
            // Read keeps the target quadword of the line
            n.cmd_addr = q.addr & `PMCS_QW_MASK;
          end else begin
            n.cmd_addr = q.addr & `PMCS_LINE_MASK;
          end
          n.cmd_valid = 1'b1;
          n.state = PMCS_ST_WAIT;
        end else if (q.kind == PMCS_K_BURST && off == 4'h0 &&
                     q.rem >= `PMCS_BURST_MIN) begin
          // Aligned middle part, at most the configured limit
          n.cmd_size = `PMCS_SZ_QBURST;
          n.cmd_qw = burst_qw;
          n.step = {4'h0, burst_qw, 4'h0};
          n.cmd_valid = 1'b1;
          n.state = PMCS_ST_WAIT;
        end else begin
          // Singles: requested, four-word lines and burst ends
          n.cmd_size = `PMCS_SZ_SINGLE;
          n.cmd_be = be_wide[15:0];
          n.step = chunk;
          n.cmd_valid = 1'b1;
          n.state = PMCS_ST_WAIT;
        end
      end
      PMCS_ST_WAIT: begin
        // Hold the command until the slave takes the address
        if (i_plb_addr_ack) begin
          n.cmd_valid = 1'b0;
          n.addr = q.addr + {23'h0, q.step};
          n.rem = q.rem - q.step;
          n.state = (q.rem == q.step) ? PMCS_ST_IDLE : PMCS_ST_PLAN;
        end
      end
      default: n.state = PMCS_ST_IDLE;
    endcase
  end

  //////////////////////////////////////////////////////////////////////
  // State register; constants only under reset
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      q <= '0;
      q.state <= PMCS_ST_IDLE;
      q.kind <= PMCS_K_SINGLE;
      q.ctl <= `PMCS_CTL_RST;
      q.adr <= `PMCS_ADR_RST;
      q.lim <= `PMCS_LIM_RST;
    end else begin
      q <= n;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Outputs; ready is combinational, the rest from flip-flops
  always_comb begin
    o_req_ready = (q.state == PMCS_ST_IDLE);
    o_reg_rdata = q.rdata;
    o_cmd_valid = q.cmd_valid;
    o_cmd_addr = q.cmd_addr;
    o_cmd_size = q.cmd_size;
    o_cmd_rnw = q.rnw;
    o_cmd_be = q.cmd_be;
    o_cmd_qwords = q.cmd_qw;
    o_match_hit = q.hit;
  end

  //////////////////////////////////////////////////////////////////////
  // Checks on the issued command stream
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_rst_b);

  sequence s_issue;
    o_cmd_valid && i_plb_addr_ack;
  endsequence

  sequence s_pending;
    o_cmd_valid && !i_plb_addr_ack;
  endsequence

  a_cmd_held_stable: assert property (
    s_pending |=> o_cmd_valid && $stable(o_cmd_addr) &&
      $stable(o_cmd_size))
    else $error("command changed before address ack");

  a_burst_in_limit: assert property (
    o_cmd_valid && o_cmd_size == `PMCS_SZ_QBURST |->
      o_cmd_qwords >= `PMCS_MIN_QW &&
      o_cmd_qwords <= (`PMCS_MIN_QW << q.lim))
    else $error("burst length outside 2 to limit");

  a_burst_aligned: assert property (
    o_cmd_valid && o_cmd_size == `PMCS_SZ_QBURST |->
      o_cmd_addr[3:0] == 4'h0)
    else $error("burst on unaligned address");

  a_no_short_line: assert property (
    o_cmd_valid |-> o_cmd_size != `PMCS_SZ_LINE4)
    else $error("four-word line issued on bus");

  a_line_read_qw: assert property (
    o_cmd_valid && o_cmd_size == `PMCS_SZ_LINE8 && o_cmd_rnw |->
      o_cmd_addr[3:0] == 4'h0)
    else $error("line read not quadword aligned");

  a_line_write_start: assert property (
    o_cmd_valid && o_cmd_size == `PMCS_SZ_LINE8 && !o_cmd_rnw |->
      o_cmd_addr[4:0] == 5'h0)
    else $error("line write not at line start");

  a_single_has_bytes: assert property (
    o_cmd_valid && o_cmd_size == `PMCS_SZ_SINGLE |->
      o_cmd_be != 16'h0)
    else $error("single with no byte enabled");

  a_capture_records: assert property (
    s_issue ##0 (hit_raw && q.ctl[`PMCS_CTL_EN]) |=>
      o_match_hit && q.hit_cnt == $past(q.hit_cnt) + 32'h1)
    else $error("match not recorded");

  a_capture_disabled: assert property (
    !q.ctl[`PMCS_CTL_EN] && !q.hit &&
      !(i_reg_wr && i_reg_addr == `PMCS_OFS_HCNT) |=>
      !o_match_hit && $stable(q.hit_cnt))
    else $error("capture while disabled");

  a_ack_releases: assert property (
    // A request taken at once on return to idle leaves the planner busy
    s_issue |=> !o_cmd_valid ##1
      (o_cmd_valid || o_req_ready || q.state == PMCS_ST_PLAN))
    else $error("no next command or idle after ack");

  a_read_one_cycle: assert property (
    i_reg_rd && i_reg_addr == `PMCS_OFS_CTL |=> o_reg_rdata == $past(q.ctl))
    else $error("control read back wrong");
endmodule // pmcs_port
`default_nettype wire

// ==== design/pmcs_map.svh ====
// Register offsets, field positions, reset values and command codes.
`ifndef PMCS_MAP_SVH
`define PMCS_MAP_SVH
// Register offsets on the plain register port
`define PMCS_OFS_STAT 8'h58
`define PMCS_OFS_HADR 8'h59
`define PMCS_OFS_HCNT 8'h5A
`define PMCS_OFS_CTL 8'h5D
`define PMCS_OFS_ADR 8'h5E
`define PMCS_OFS_LIM 8'h5F
// Match control field positions
`define PMCS_CTL_EN 0
`define PMCS_SIZE_HI 7
`define PMCS_SIZE_LO 4
`define PMCS_RNW 8
`define PMCS_MID_HI 11
`define PMCS_MID_LO 9
`define PMCS_SRC 12
`define PMCS_LMID_HI 15
`define PMCS_LMID_LO 14
`define PMCS_SSZ_HI 17
`define PMCS_SSZ_LO 16
`define PMCS_EN_SIZE 25
`define PMCS_EN_RNW 26
`define PMCS_EN_MID 27
`define PMCS_EN_SRC 28
`define PMCS_EN_LMID 29
`define PMCS_EN_SSZ 30
`define PMCS_EN_ADDR 31
// Reset values
`define PMCS_CTL_RST 32'h0
`define PMCS_ADR_RST 32'h0
`define PMCS_LIM_RST 2'h2
// Bus size codes issued with each command
`define PMCS_SZ_SINGLE 4'h0
`define PMCS_SZ_LINE4 4'h1
`define PMCS_SZ_LINE8 4'h2
`define PMCS_SZ_QBURST 4'hC
// Byte counts and alignment masks
`define PMCS_QW_BYTES 13'h010
`define PMCS_LINE_BYTES 13'h020
`define PMCS_BURST_MIN 13'h020
`define PMCS_QW_MASK 36'hFFFFFFFF0
`define PMCS_LINE_MASK 36'hFFFFFFFE0
`define PMCS_MIN_QW 5'h02
`define PMCS_STAT_HIT 0
`endif

// ==== design/pmcs_pkg.sv ====
// Types shared by the master port command splitter and its matcher.
`default_nettype none
package pmcs_pkg;
  // Sequencer states
  typedef enum logic [1:0] {
    PMCS_ST_IDLE,
    PMCS_ST_PLAN,
    PMCS_ST_WAIT
  } pmcs_state_t;
  // Upstream request kinds
  typedef enum logic [1:0] {
    PMCS_K_SINGLE,
    PMCS_K_BURST,
    PMCS_K_LINE4,
    PMCS_K_LINE8
  } pmcs_kind_t;
  // Whole state of the port
  typedef struct packed {
    pmcs_state_t state;
    pmcs_kind_t kind;
    logic rnw;
    logic [2:0] mid;
    logic src;
    logic [1:0] lmid;
    logic [35:0] addr;
    logic [12:0] rem;
    logic [12:0] step;
    logic cmd_valid;
    logic [35:0] cmd_addr;
    logic [3:0] cmd_size;
    logic [15:0] cmd_be;
    logic [4:0] cmd_qw;
    logic [31:0] ctl;
    logic [31:0] adr;
    logic [1:0] lim;
    logic hit;
    logic [31:0] hit_addr;
    logic [31:0] hit_cnt;
    logic [31:0] rdata;
  } pmcs_regs_t;
endpackage
`default_nettype wire

// ==== design/pmcs_matcher.sv ====
// Compares one issued command against the programmed match criteria.
`default_nettype none
`include "pmcs_map.svh"
module pmcs_matcher
  import pmcs_pkg::*;
(
  input wire logic [31:0] i_ctl, // Match control word
  input wire logic [31:0] i_adr, // Low address word to compare
  input wire logic [3:0] i_size, // Issued size code
  input wire logic i_rnw, // Issued direction
  input wire logic [2:0] i_mid, // Originating master number
  input wire logic i_src, // 1: via slave port, 0: DMA
  input wire logic [1:0] i_lmid, // External logic master number
  input wire logic [1:0] i_ssize, // Slave width code from the bus
  input wire logic [31:0] i_addr, // Low 32 bits of issued address
  output logic o_hit // All enabled criteria equal
);
  logic ok_size; // Per-criterion results
  logic ok_rnw;
  logic ok_mid;
  logic ok_src;
  logic ok_lmid;
  logic ok_ssz;
  logic ok_addr;

  //////////////////////////////////////////////////////////////////////
  // A disabled criterion always passes
  always_comb begin
    ok_size = !i_ctl[`PMCS_EN_SIZE] ||
      (i_ctl[`PMCS_SIZE_HI:`PMCS_SIZE_LO] == i_size);
    ok_rnw = !i_ctl[`PMCS_EN_RNW] ||
      (i_ctl[`PMCS_RNW] == i_rnw);
    ok_mid = !i_ctl[`PMCS_EN_MID] ||
      (i_ctl[`PMCS_MID_HI:`PMCS_MID_LO] == i_mid);
    ok_src = !i_ctl[`PMCS_EN_SRC] ||
      (i_ctl[`PMCS_SRC] == i_src);
    ok_lmid = !i_ctl[`PMCS_EN_LMID] ||
      (i_ctl[`PMCS_LMID_HI:`PMCS_LMID_LO] == i_lmid);
    ok_ssz = !i_ctl[`PMCS_EN_SSZ] ||
      (i_ctl[`PMCS_SSZ_HI:`PMCS_SSZ_LO] == i_ssize);
    // Only the low word of the wide address takes part
    ok_addr = !i_ctl[`PMCS_EN_ADDR] || (i_adr == i_addr);
    o_hit = ok_size && ok_rnw && ok_mid && ok_src &&
      ok_lmid && ok_ssz && ok_addr;
  end
endmodule // pmcs_matcher
`default_nettype wire

// ==== sim/pmcs_slave_model.sv ====
// Bus slave and arbiter stand-in that acknowledges issued commands.
`default_nettype none
module pmcs_slave_model (
  input wire logic i_core_clk, // Clock
  input wire logic i_rst_b, // Reset, active low
  input wire logic i_cmd_valid, // Command from the port
  input wire logic [1:0] i_delay, // Wait before the ack
  input wire logic [1:0] i_width, // Width code this slave reports
  output logic o_addr_ack, // One-cycle address acknowledge
  output logic [1:0] o_ssize // Width code, meaningful with ack only
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] wait_q; // Cycles waited on the current command
  //////////////////////////////////////////////////////////////////////
  // Burst and line capable, so such commands are legal here
  // Takes any burst length: buffering is deep enough
  // No read data path, so line read order is never broken
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_addr_ack <= 1'b0;
      wait_q <= 2'h0;
    end else if (o_addr_ack || !i_cmd_valid) begin
      // Ack lasts one cycle; the next piece starts a fresh wait
      o_addr_ack <= 1'b0;
      wait_q <= 2'h0;
    end else if (wait_q >= i_delay) begin
      o_addr_ack <= 1'b1;
    end else begin
      wait_q <= wait_q + 2'h1;
    end
  end
  // Outside the ack the width lines show garbage, not the last value
  assign o_ssize = o_addr_ack ? i_width : ~i_width;
endmodule // pmcs_slave_model
`default_nettype wire

// ==== sim/tb_pmcs_port.sv ====
// Self-checking bench for the master port and its command matcher.
`default_nettype none
`include "pmcs_map.svh"
module tb_pmcs_port;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rst_b = 0, reg_wr = 0, reg_rd = 0; // Clock, strobes
  logic [7:0] reg_addr = 8'h00; // Register offset
  logic [31:0] reg_wdata = 32'h0, reg_rdata; // Register data
  logic req_valid = 0, req_ready, req_rnw = 0, req_src = 0; // Request
  logic [1:0] req_kind = 2'h0, req_lmid = 2'h0, dly = 2'h0, width = 2'h0;
  logic [35:0] req_addr = 36'h0, cmd_addr; // Addresses
  logic [12:0] req_len = 13'h0; // Byte count
  logic [2:0] req_mid = 3'h0; // Master number
  logic cmd_valid, cmd_rnw, ack, hit; // Bus side
  logic [3:0] cmd_size; // Size code
  logic [15:0] cmd_be; // Byte enables
  logic [4:0] cmd_qw; // Burst length
  logic [1:0] ssize; // Slave width code
  int error_cnt = 0, comparisons = 0, cyc = 0, lim_m = 8, exp_cnt = 0;
  integer seed = 32'hf62254b6; // Fixed seed
  logic exp_hit = 0; // Model of the sticky flag
  logic [31:0] exp_last = 0, ctl_m = 0, adr_m = 0, rv, c; // Mirrors
  logic [61:0] exq[$], obq[$]; // Expected and seen commands
  //////////////////////////////////////////////////////////////////////
  pmcs_port u_pmcs_port (.i_core_clk(clk), .i_rst_b(rst_b),
    .i_reg_addr(reg_addr), .i_reg_wdata(reg_wdata), .i_reg_wr(reg_wr),
    .i_reg_rd(reg_rd), .o_reg_rdata(reg_rdata), .i_req_valid(req_valid),
    .o_req_ready(req_ready), .i_req_kind(req_kind), .i_req_addr(req_addr),
    .i_req_len(req_len), .i_req_rnw(req_rnw), .i_req_mid(req_mid),
    .i_req_from_slave_port(req_src), .i_req_lmid(req_lmid),
    .o_cmd_valid(cmd_valid), .o_cmd_addr(cmd_addr), .o_cmd_size(cmd_size),
    .o_cmd_rnw(cmd_rnw), .o_cmd_be(cmd_be), .o_cmd_qwords(cmd_qw),
    .i_plb_addr_ack(ack), .i_plb_ssize(ssize), .o_match_hit(hit));
  pmcs_slave_model u_pmcs_slave_model (.i_core_clk(clk), .i_rst_b(rst_b),
    .i_cmd_valid(cmd_valid), .i_delay(dly), .i_width(width),
    .o_addr_ack(ack), .o_ssize(ssize));
  //////////////////////////////////////////////////////////////////////
  // Clock at 100 MHz
  initial begin
    forever #5 clk = ~clk;
  end
  // Hang guard: far above the few thousand cycles the run needs
  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      error_cnt++;
      test_done();
    end
  end
  // Record each accepted command and model the matcher on it
  always @(posedge clk) begin
    if (rst_b && cmd_valid && ack) begin
      obq.push_back({cmd_addr, cmd_size, cmd_rnw, cmd_be, cmd_qw});
      if (ctl_m[0] && (!ctl_m[25] || ctl_m[7:4] == cmd_size) &&
          (!ctl_m[26] || ctl_m[8] == cmd_rnw) &&
          (!ctl_m[27] || ctl_m[11:9] == req_mid) &&
          (!ctl_m[28] || ctl_m[12] == req_src) &&
          (!ctl_m[29] || ctl_m[15:14] == req_lmid) &&
          (!ctl_m[30] || ctl_m[17:16] == ssize) &&
          (!ctl_m[31] || adr_m == cmd_addr[31:0])) begin
        exp_hit = 1'b1;
        exp_cnt++;
        exp_last = cmd_addr[31:0];
      end
    end
  end
  //////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [63:0] e,
                     input logic [63:0] g);
    comparisons++;
    if (g !== e) begin
      error_cnt++;
      $display("BAD %s expected %0h seen %0h", what, e, g);
    end
  endtask
  // One write cycle; mirrors follow what the register file should do
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    if (a == `PMCS_OFS_CTL) ctl_m = d;
    if (a == `PMCS_OFS_ADR) adr_m = d;
    if (a == `PMCS_OFS_LIM) lim_m = 2 << d[1:0];
    if (a == `PMCS_OFS_STAT && d[0]) exp_hit = 1'b0;
    if (a == `PMCS_OFS_HCNT) exp_cnt = 0;
  endtask
  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic single(inout logic [35:0] a, inout int len, input logic r);
    int n;
    logic [31:0] m;
    n = (len < 16 - a[3:0]) ? len : 16 - a[3:0];
    m = ((32'h1 << n) - 1) << a[3:0];
    exq.push_back({a, `PMCS_SZ_SINGLE, r, m[15:0], 5'h0});
    a += n;
    len -= n;
  endtask
  // Expected pieces of one request
  task automatic plan(input logic [1:0] k, input logic [35:0] a,
                      input int len, input logic r);
    int q;
    if (k == 2'h2) begin
      exq.push_back({a & ~36'hF, `PMCS_SZ_SINGLE, r, 16'hFFFF, 5'h0});
    end else if (k == 2'h3) begin
      exq.push_back({r ? a & ~36'hF : a & ~36'h1F, `PMCS_SZ_LINE8, r,
                     16'hFFFF, 5'h0});
    end else begin
      if (k == 2'h1 && a[3:0] != 4'h0) single(a, len, r);
      while (k == 2'h1 && len >= 32) begin
        q = (len / 16 > lim_m) ? lim_m : len / 16;
        exq.push_back({a, `PMCS_SZ_QBURST, r, 16'hFFFF, 5'(q)});
        a += 36'(q * 16);
        len -= q * 16;
      end
      while (len > 0) single(a, len, r);
    end
  endtask
  // Issue one request, wait for the port to go idle, compare all results
  task automatic send(input logic [1:0] k, input logic [35:0] a,
                      input int len, input logic r);
    plan(k, a, len, r);
    @(posedge clk);
    req_valid <= 1'b1;
    req_kind <= k;
    req_addr <= a;
    req_len <= 13'(len);
    req_rnw <= r;
    dly <= 2'($random(seed));
    width <= 2'($random(seed));
    for (int n = 0; n < 50; n++) begin
      @(posedge clk);
      if (req_ready === 1'b1) break;
    end
    req_valid <= 1'b0;
    for (int n = 0; n < 3000; n++) begin
      @(posedge clk);
      #1;
      if (req_ready === 1'b1) break;
    end
    chk("port idle", 1'b1, req_ready);
    chk("piece count", exq.size(), obq.size());
    while (exq.size() > 0 && obq.size() > 0) begin
      chk("command", exq.pop_front(), obq.pop_front());
    end
    exq.delete();
    obq.delete();
    rd(`PMCS_OFS_HCNT, rv);
    chk("hit count", exp_cnt, rv);
    rd(`PMCS_OFS_STAT, rv);
    chk("hit flag", {31'h0, exp_hit}, rv);
    chk("hit pin", exp_hit, hit);
    rd(`PMCS_OFS_HADR, rv);
    chk("hit address", exp_last, rv);
  endtask
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////
  initial begin
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    // Reset values, read-back, unmapped offset
    rd(`PMCS_OFS_CTL, rv);
    chk("control reset", `PMCS_CTL_RST, rv);
    rd(`PMCS_OFS_LIM, rv);
    chk("limit reset", `PMCS_LIM_RST, rv);
    wr(8'h60, 32'hFFFFFFFF);
    rd(8'h60, rv);
    chk("unmapped", 32'h0, rv);
    wr(`PMCS_OFS_CTL, 32'hFEC3DFFE);
    rd(`PMCS_OFS_CTL, rv);
    chk("control rw", 32'hFEC3DFFE, rv);
    wr(`PMCS_OFS_ADR, 32'hA5C3F00F);
    rd(`PMCS_OFS_ADR, rv);
    chk("address rw", 32'hA5C3F00F, rv);
    $display("test registers done");
    // Every burst limit, unaligned head and tail; lines of both kinds
    for (int i = 0; i < 4; i++) begin
      wr(`PMCS_OFS_LIM, i);
      send(2'h1, 36'h900000007, 300, i[0]);
      send(2'h1, 36'h40, 256, 1'b0);
    end
    send(2'h0, 36'h1C, 8, 1'b1);
    send(2'h2, 36'h3C, 0, 1'b1);
    send(2'h3, 36'h1C, 0, 1'b1);
    send(2'h3, 36'h1C, 0, 1'b0);
    $display("test transfers done");
    // Size criterion with capture off, then on
    wr(`PMCS_OFS_CTL, 32'h020000C0);
    send(2'h1, 36'h0, 64, 1'b1);
    wr(`PMCS_OFS_CTL, 32'h020000C1);
    send(2'h1, 36'h0, 64, 1'b1);
    $display("test match enable done");
    // Random requests under random criteria and limits
    repeat (60) begin
      // Drive on the edge; direction varies too
      @(posedge clk);
      req_rnw <= 1'($random(seed));
      req_mid <= 3'($random(seed));
      req_src <= 1'($random(seed));
      req_lmid <= 2'($random(seed));
      @(posedge clk);
      c = $random(seed);
      c[8] = req_rnw;
      c[11:9] = req_mid;
      c[12] = req_src;
      c[15:14] = req_lmid;
      c[7:4] = c[1] ? `PMCS_SZ_QBURST : `PMCS_SZ_SINGLE;
      wr(`PMCS_OFS_CTL, c);
      wr(`PMCS_OFS_LIM, 32'($random(seed)) & 32'h3);
      rv = $random(seed);
      wr(`PMCS_OFS_ADR, {rv[31:12], 12'h0});
      send(2'($random(seed)), {4'h0, rv[31:12], 4'(rv), 8'h0} +
           36'(rv[3:0]), 1 + ($unsigned($random(seed)) % 300),
           req_rnw);
    end
    $display("test random done");
    // Clearing the status flag and the count
    wr(`PMCS_OFS_STAT, 32'h1);
    wr(`PMCS_OFS_HCNT, 32'h0);
    rd(`PMCS_OFS_STAT, rv);
    chk("flag clear", 32'h0, rv);
    rd(`PMCS_OFS_HCNT, rv);
    chk("count clear", 32'h0, rv);
    $display("test clear done");
    test_done();
  end
endmodule // tb_pmcs_port
`default_nettype wire
